// ===== common/rdl_pkg.sv
package rdl_pkg;

    // Register map, byte addresses
    localparam logic [11:0] ROUTE_SEL_OFFSET  = 12'h10c;
    localparam logic [11:0] ROUTE_STAT_OFFSET = 12'h110;

    // Field positions in the route select register
    localparam int LINK_ROUTE_LSB = 0;
    localparam int DE_ROUTE_LSB   = 2;
    localparam int LINK_RATE_LSB  = 4;

    // Values after reset
    localparam logic [1:0] LINK_ROUTE_RST = 2'h0;
    localparam logic [1:0] DE_ROUTE_RST   = 2'h0;
    localparam logic [1:0] LINK_RATE_RST  = 2'h0;
    localparam logic [1:0] FRAME_IDX_RST  = 2'h0;

    // Link rate codes
    localparam logic [1:0] RATE_EVERY  = 2'h0;
    localparam logic [1:0] RATE_ODD    = 2'h1;
    localparam logic [1:0] RATE_EVEN   = 2'h2;

    // D/E slot route codes
    localparam logic [1:0] DE_TO_SERIAL = 2'h0;
    localparam logic [1:0] DE_TO_LAPD   = 2'h1;
    localparam logic [1:0] DE_TO_FRAC   = 2'h3;

    // Link route codes
    localparam logic [1:0] LINK_TO_LAPD_SER = 2'h0;
    localparam logic [1:0] LINK_TO_SER      = 2'h1;
    localparam logic [1:0] LINK_TO_OH_SER   = 2'h2;
    localparam logic [1:0] LINK_FORCE_ONES  = 2'h3;

    // Frame index within a group of four, frame 1 of the superframe is 1
    localparam logic [1:0] FRAME_FIRST = 2'h1;
    localparam logic [1:0] FRAME_ODD   = 2'h1;
    localparam logic [1:0] FRAME_EVEN  = 2'h3;

    // Buffer towards the receive LAPD controller
    localparam int LAPD_FIFO_DEPTH = 16;
    localparam int LAPD_FIFO_WIDTH = 2;

    // AXI responses
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // Framing format of the incoming line
    typedef enum logic [2:0] {
        FMT_ESF   = 3'h0,
        FMT_SF    = 3'h1,
        FMT_SLC96 = 3'h2,
        FMT_N     = 3'h3,
        FMT_T1DM  = 3'h4
    } rdl_format_t;

    // One received bit from the framer
    typedef struct packed {
        logic dataBit;   // Received bit value
        logic fBit;      // Bit is a framing bit
        logic deBit;     // Bit lies in the D/E time slot
        logic sfStart;   // Framing bit of superframe frame 1
    } rdl_stream_t;

    // Item handed to the LAPD controller
    typedef struct packed {
        logic fromDe;    // 1: D/E slot bit, 0: data link bit
        logic dataBit;   // Bit value
    } rdl_lapd_t;

    // Bit with strobe on an output pin
    typedef struct packed {
        logic stb;       // One-cycle strobe
        logic dataBit;   // Bit value
    } rdl_pin_t;

endpackage

// ===== verilog/rdl_fifo.sv
`timescale 1ns/100ps
module rdl_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input  wire logic                       sys_clk,  // System clock
    input  wire logic                       reset,    // Synchronous reset
    input  wire logic [WIDTH-1:0]           inData,   // Write data
    input  wire logic                       inValid,  // Write request
    output logic                            inReady,  // Not full
    output logic [WIDTH-1:0]                outData,  // Head of queue
    output logic                            outValid, // Not empty
    input  wire logic                       outReady, // Reader takes head
    output logic [$clog2(DEPTH+1)-1:0]      level     // Words stored
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0]         mem [DEPTH];
    logic [AW-1:0]            wrPtr_q;
    logic [AW-1:0]            rdPtr_q;
    logic [$clog2(DEPTH+1)-1:0] count_q;
    logic                     push;
    logic                     pop;

    // Handshakes and flags
    assign inReady  = (count_q != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign outValid = (count_q != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[rdPtr_q];
    assign level    = count_q;

    // Storage
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// ===== verilog/rdl_frame_pos.sv
`timescale 1ns/100ps
module rdl_frame_pos (
    input  wire logic       sys_clk,  // System clock
    input  wire logic       reset,    // Synchronous reset
    input  wire logic       fbitStep, // Framing bit accepted
    input  wire logic       sfStart,  // That framing bit opens frame 1
    output logic [1:0]      curIdx,   // Index of the current frame, mod 4
    output logic [1:0]      lastIdx   // Index of the last framing bit
);
    logic [1:0] idx_q;
    logic [1:0] idx_d;

    // Superframe start realigns, otherwise count on
    always_comb begin
        idx_d = sfStart ? rdl_pkg::FRAME_FIRST : idx_q + 2'h1;
    end

    assign curIdx  = idx_d;
    assign lastIdx = idx_q;

    // Remember index of each framing bit
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            idx_q <= rdl_pkg::FRAME_IDX_RST;
        end else if (fbitStep) begin
            idx_q <= idx_d;
        end
    end
endmodule

// ===== verilog/rdl_route_top.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module rdl_route_top (
    input  wire logic                 sys_clk,     // System clock, 100 MHz
    input  wire logic                 reset,       // Synchronous reset
    // AXI4-Lite slave
    input  wire logic [11:0]          s_awaddr,    // Write address
    input  wire logic                 s_awvalid,   // Write address valid
    output logic                      s_awready,   // Write address ready
    input  wire logic [31:0]          s_wdata,     // Write data
    input  wire logic [3:0]           s_wstrb,     // Write byte enables
    input  wire logic                 s_wvalid,    // Write data valid
    output logic                      s_wready,    // Write data ready
    output logic [1:0]                s_bresp,     // Write response
    output logic                      s_bvalid,    // Write response valid
    input  wire logic                 s_bready,    // Write response ready
    input  wire logic [11:0]          s_araddr,    // Read address
    input  wire logic                 s_arvalid,   // Read address valid
    output logic                      s_arready,   // Read address ready
    output logic [31:0]               s_rdata,     // Read data
    output logic [1:0]                s_rresp,     // Read response
    output logic                      s_rvalid,    // Read data valid
    input  wire logic                 s_rready,    // Read data ready
    // Receive stream from the framer
    input  wire rdl_pkg::rdl_format_t lineFormat,  // Framing format in use
    input  wire rdl_pkg::rdl_stream_t inBit,       // Received bit
    input  wire logic                 inValid,     // Bit offered
    output logic                      inReady,     // Bit taken
    // Output pins
    output rdl_pkg::rdl_pin_t         rx_serial_out,     // Serial data out
    output rdl_pkg::rdl_pin_t         rx_overhead_out,   // Overhead out
    output rdl_pkg::rdl_pin_t         rx_fractional_out, // Fractional out
    // Receive LAPD controller one
    output rdl_pkg::rdl_lapd_t        lapdData,    // Bit for the controller
    output logic                      lapdValid,   // Bit available
    input  wire logic                 lapdReady    // Controller takes bit
);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and status state

    logic [1:0]  rx_link_rate_select_q;
    logic [1:0]  rx_de_slot_route_q;
    logic [1:0]  rx_link_route_q;

    logic [11:0] awAddr_q;
    logic        awHeld_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        wHeld_q;
    logic        bValid_q;
    logic [1:0]  bResp_q;
    logic        rValid_q;
    logic [31:0] rData_q;
    logic [1:0]  rResp_q;
    logic        doWrite;

    logic [1:0]  frameIdx;
    logic [1:0]  lastIdx;
    logic        accept;
    logic        isLink;
    logic        isDe;
    logic        pushLapd;
    logic        fifoInReady;
    rdl_pkg::rdl_lapd_t lapdItem;
    logic [4:0]  fifoLevel;

    rdl_pkg::rdl_pin_t serial_q;
    rdl_pkg::rdl_pin_t serial_d;
    rdl_pkg::rdl_pin_t oh_q;
    rdl_pkg::rdl_pin_t oh_d;
    rdl_pkg::rdl_pin_t frac_q;
    rdl_pkg::rdl_pin_t frac_d;

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Whether a framing bit carries the data link
    function automatic logic link_slot(
        input rdl_pkg::rdl_format_t fmt,
        input logic [1:0]           rate,
        input logic [1:0]           idx
    );
        logic hit;
        hit = 1'b0;
        case (fmt)
            rdl_pkg::FMT_T1DM: begin
                hit = 1'b1;
            end
            rdl_pkg::FMT_ESF: begin
                case (rate)
                    rdl_pkg::RATE_ODD: begin
                        hit = (idx == rdl_pkg::FRAME_ODD);
                    end
                    rdl_pkg::RATE_EVEN: begin
                        hit = (idx == rdl_pkg::FRAME_EVEN);
                    end
                    default: begin
                        hit = idx[0];
                    end
                endcase
            end
            default: begin
                hit = idx[0];
            end
        endcase
        return hit;
    endfunction

    // Register read view
    function automatic logic [31:0] reg_view(
        input logic [11:0] addr,
        input logic [1:0]  rate,
        input logic [1:0]  deRoute,
        input logic [1:0]  lnRoute,
        input logic [4:0]  level,
        input logic [1:0]  idx
    );
        logic [31:0] v;
        v = 32'h0;
        if (addr == rdl_pkg::ROUTE_SEL_OFFSET) begin
            v[rdl_pkg::LINK_RATE_LSB +: 2]  = rate;
            v[rdl_pkg::DE_ROUTE_LSB +: 2]   = deRoute;
            v[rdl_pkg::LINK_ROUTE_LSB +: 2] = lnRoute;
        end else if (addr == rdl_pkg::ROUTE_STAT_OFFSET) begin
            v[4:0] = level;
            v[9:8] = idx;
        end
        return v;
    endfunction

    // Known register address
    function automatic logic reg_hit(input logic [11:0] addr);
        return (addr == rdl_pkg::ROUTE_SEL_OFFSET) || (addr == rdl_pkg::ROUTE_STAT_OFFSET);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    assign s_awready = !awHeld_q && !bValid_q;
    assign s_wready  = !wHeld_q && !bValid_q;
    assign s_bvalid  = bValid_q;
    assign s_bresp   = bResp_q;
    assign doWrite   = awHeld_q && wHeld_q && !bValid_q;

    // Hold address and data until both are in
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 12'h0;
            wHeld_q  <= 1'b0;
            wData_q  <= 32'h0;
            wStrb_q  <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_wdata;
                wStrb_q <= s_wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bValid_q <= 1'b0;
            bResp_q  <= rdl_pkg::AXI_OKAY;
        end else if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q  <= reg_hit(awAddr_q) ? rdl_pkg::AXI_OKAY : rdl_pkg::AXI_SLVERR;
        end else if (s_bready) begin
            bValid_q <= 1'b0;
        end
    end

    // Route select fields, low byte lane only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_link_rate_select_q <= rdl_pkg::LINK_RATE_RST;
            rx_de_slot_route_q    <= rdl_pkg::DE_ROUTE_RST;
            rx_link_route_q       <= rdl_pkg::LINK_ROUTE_RST;
        end else if (doWrite && wStrb_q[0] && awAddr_q == rdl_pkg::ROUTE_SEL_OFFSET) begin
            rx_link_rate_select_q <= wData_q[rdl_pkg::LINK_RATE_LSB +: 2];
            rx_de_slot_route_q    <= wData_q[rdl_pkg::DE_ROUTE_LSB +: 2];
            rx_link_route_q       <= wData_q[rdl_pkg::LINK_ROUTE_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    assign s_arready = !rValid_q;
    assign s_rvalid  = rValid_q;
    assign s_rdata   = rData_q;
    assign s_rresp   = rResp_q;

    // Read data captured on address acceptance
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rValid_q <= 1'b0;
            rData_q  <= 32'h0;
            rResp_q  <= rdl_pkg::AXI_OKAY;
        end else if (s_arvalid && s_arready) begin
            rValid_q <= 1'b1;
            rData_q  <= reg_view(s_araddr, rx_link_rate_select_q, rx_de_slot_route_q,
                                 rx_link_route_q, fifoLevel, lastIdx);
            rResp_q  <= reg_hit(s_araddr) ? rdl_pkg::AXI_OKAY : rdl_pkg::AXI_SLVERR;
        end else if (s_rready) begin
            rValid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame position tracking

    rdl_frame_pos u_frame_pos (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .fbitStep (accept && inBit.fBit),
        .sfStart  (inBit.sfStart),
        .curIdx   (frameIdx),
        .lastIdx  (lastIdx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bit classification and back-pressure

    // A bit bound for the LAPD buffer stalls the stream while it is full
    assign isLink   = inBit.fBit && link_slot(lineFormat, rx_link_rate_select_q, frameIdx);
    assign isDe     = inBit.deBit && !inBit.fBit;
    assign pushLapd = (isLink && rx_link_route_q == rdl_pkg::LINK_TO_LAPD_SER)
                   || (isDe && rx_de_slot_route_q == rdl_pkg::DE_TO_LAPD);
    assign inReady  = fifoInReady || !pushLapd;
    assign accept   = inValid && inReady;

    assign lapdItem.fromDe  = isDe;
    assign lapdItem.dataBit = inBit.dataBit;

    ////////////////////////////////////////////////////////////////////////////
    // Output pin selection

    // Serial output carries every bit; link and D/E bits per route
    always_comb begin
        serial_d.stb     = accept;
        serial_d.dataBit = inBit.dataBit;
        if (isLink && rx_link_route_q == rdl_pkg::LINK_FORCE_ONES) begin
            serial_d.dataBit = 1'b1;
        end else if (isDe && rx_de_slot_route_q != rdl_pkg::DE_TO_SERIAL
                     && rx_de_slot_route_q != 2'h2) begin
            serial_d.dataBit = 1'b1;
        end
    end

    // Overhead output gets link bits only in route 10
    always_comb begin
        oh_d.stb     = accept && isLink && rx_link_route_q == rdl_pkg::LINK_TO_OH_SER;
        oh_d.dataBit = inBit.dataBit;
    end

    // Fractional output gets D/E bits only in route 11
    always_comb begin
        frac_d.stb     = accept && isDe && rx_de_slot_route_q == rdl_pkg::DE_TO_FRAC;
        frac_d.dataBit = inBit.dataBit;
    end

    // Output pins registered; route 01 leaves link bits on serial only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            serial_q <= '0;
            oh_q     <= '0;
            frac_q   <= '0;
        end else begin
            serial_q <= serial_d;
            oh_q     <= oh_d;
            frac_q   <= frac_d;
        end
    end

    assign rx_serial_out     = serial_q;
    assign rx_overhead_out   = oh_q;
    assign rx_fractional_out = frac_q;

    ////////////////////////////////////////////////////////////////////////////
    // Buffer towards LAPD controller one

    rdl_fifo #(
        .WIDTH (rdl_pkg::LAPD_FIFO_WIDTH),
        .DEPTH (rdl_pkg::LAPD_FIFO_DEPTH)
    ) u_lapd_fifo (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .inData   (lapdItem),
        .inValid  (inValid && pushLapd),
        .inReady  (fifoInReady),
        .outData  (lapdData),
        .outValid (lapdValid),
        .outReady (lapdReady),
        .level    (fifoLevel)
    );

endmodule

// ===== test/rdl_route_asserts.sv
`timescale 1ns/100ps
module rdl_route_asserts (
    input  wire logic                 sys_clk,           // Clock
    input  wire logic                 reset,             // Reset
    input  wire logic                 s_awvalid,         // AW valid
    input  wire logic                 s_awready,         // AW ready
    input  wire logic                 s_wvalid,          // W valid
    input  wire logic                 s_wready,          // W ready
    input  wire logic                 s_bvalid,          // B valid
    input  wire logic                 s_arvalid,         // AR valid
    input  wire logic                 s_arready,         // AR ready
    input  wire logic                 s_rvalid,          // R valid
    input  wire rdl_pkg::rdl_stream_t inBit,             // Stream bit
    input  wire logic                 inValid,           // Bit offered
    input  wire logic                 inReady,           // Bit taken
    input  wire rdl_pkg::rdl_pin_t    rx_serial_out,     // Serial pin
    input  wire rdl_pkg::rdl_pin_t    rx_overhead_out,   // Overhead pin
    input  wire rdl_pkg::rdl_pin_t    rx_fractional_out, // Fractional pin
    input  wire rdl_pkg::rdl_lapd_t   lapdData,          // LAPD head
    input  wire logic                 lapdValid,         // LAPD valid
    input  wire logic                 lapdReady          // LAPD pop
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////
    // Register bus handshakes
    a_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid)
        else $error("write response missing");
    a_write_blocks: assert property (s_bvalid |-> !s_awready && !s_wready)
        else $error("write accepted during response");
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read data late");
    a_read_blocks: assert property (s_rvalid |-> !s_arready)
        else $error("read accepted during data");

    ////////////////////////////////////////////////////////////////////////////
    // Stream routing
    a_serial_pulse: assert property (inValid && inReady |=> rx_serial_out.stb)
        else $error("serial strobe missing");
    a_serial_idle: assert property (!(inValid && inReady) |=> !rx_serial_out.stb)
        else $error("serial strobe without bit");
    a_oh_link_only: assert property (rx_overhead_out.stb |-> rx_serial_out.stb && $past(inBit.fBit))
        else $error("overhead strobe on non-link bit");
    a_frac_de_only: assert property (rx_fractional_out.stb |-> $past(inBit.deBit && !inBit.fBit) && !rx_overhead_out.stb)
        else $error("fractional strobe on non-slot bit");
    a_lapd_hold: assert property (lapdValid && !lapdReady |=> lapdValid && $stable(lapdData))
        else $error("LAPD head changed while waiting");
endmodule

bind rdl_route_top rdl_route_asserts u_rdl_route_asserts (.*);

// ===== test/rdl_lapd_model.sv
`timescale 1ns/100ps
module rdl_lapd_model (
    input  wire logic               sys_clk,   // Clock
    input  wire logic               reset,     // Reset
    input  wire rdl_pkg::rdl_lapd_t lapdData,  // Head item
    input  wire logic               lapdValid, // Head valid
    input  wire logic               stall,     // Hold off pops
    output logic                    lapdReady  // Pop request
);
    rdl_pkg::rdl_lapd_t got[$];

    // Controller one pops when not stalled and logs each item
    always @(posedge sys_clk) begin
        lapdReady <= !stall && !reset;
        if (lapdValid === 1'b1 && lapdReady === 1'b1) begin
            got.push_back(lapdData);
        end
    end
endmodule

// ===== test/rdl_route_top_test.sv
`timescale 1ns/100ps
module rdl_route_top_test;
    logic                 sys_clk, reset, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic                 s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic                 inValid, inReady, lapdValid, lapdReady, stall;
    logic [11:0]          s_awaddr, s_araddr;
    logic [31:0]          s_wdata, s_rdata;
    logic [3:0]           s_wstrb;
    logic [1:0]           s_bresp, s_rresp;
    rdl_pkg::rdl_format_t lineFormat;
    rdl_pkg::rdl_stream_t inBit;
    rdl_pkg::rdl_pin_t    serOut, ohOut, frOut;
    rdl_pkg::rdl_lapd_t   lapdData;
    int                   miscompares = 0, compares = 0, cycles = 0;

    rdl_route_top u_rdl_route_top (.rx_serial_out(serOut), .rx_overhead_out(ohOut),
        .rx_fractional_out(frOut), .*);
    rdl_lapd_model u_rdl_lapd_model (.*);

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wrChk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge sys_clk);
        s_awaddr <= a; s_wdata <= d; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
        do begin
            @(negedge sys_clk);
            ta = s_awvalid && s_awready === 1'b1;
            tw = s_wvalid && s_wready === 1'b1;
            tb = s_bvalid === 1'b1;
            if (tb) chk(s_bresp, er, "write response");
            @(posedge sys_clk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
            if (tb) s_bready <= 1'b0;
        end while (!tb);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        @(posedge sys_clk);
        s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
        do begin
            @(negedge sys_clk);
            ta = s_arvalid && s_arready === 1'b1;
            tr = s_rvalid === 1'b1;
            if (tr) chk(s_rdata, ed, "read data");
            if (tr) chk(s_rresp, er, "read response");
            @(posedge sys_clk);
            if (ta) s_arvalid <= 1'b0;
            if (tr) s_rready <= 1'b0;
        end while (!tr);
    endtask
    // Offer one bit, then judge serial data, overhead and fractional strobes
    task automatic sendBit(input rdl_pkg::rdl_stream_t b, input logic [2:0] e);
        @(posedge sys_clk);
        inBit <= b; inValid <= 1'b1;
        do @(negedge sys_clk); while (inReady !== 1'b1);
        @(posedge sys_clk);
        inValid <= 1'b0;
        @(negedge sys_clk);
        chk(serOut.stb, 1'b1, "serial strobe");
        chk({serOut.dataBit, ohOut.stb, frOut.stb}, e, "pin outputs");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_regs();
        rdChk(12'h10c, 32'h0, rdl_pkg::AXI_OKAY);
        wrChk(12'h10c, 32'hff, rdl_pkg::AXI_OKAY);
        rdChk(12'h10c, 32'h3f, rdl_pkg::AXI_OKAY);
        wrChk(12'h200, 32'h0, rdl_pkg::AXI_SLVERR);
        rdChk(12'h200, 32'h0, rdl_pkg::AXI_SLVERR);
        rdChk(12'h10c, 32'h3f, rdl_pkg::AXI_OKAY);
        $display("test_regs done");
    endtask
    task automatic test_link_routes();
        for (int r = 0; r < 4; r++) begin
            wrChk(12'h10c, r, rdl_pkg::AXI_OKAY);
            u_rdl_lapd_model.got.delete();
            sendBit(4'h5, {r == 3, r == 2, 1'b0});
            sendBit(4'h4, 3'h0);
            repeat (3) @(posedge sys_clk);
            chk(u_rdl_lapd_model.got.size(), r == 0, "link to LAPD");
        end
        $display("test_link_routes done");
    endtask
    task automatic test_rates();
        rdl_pkg::rdl_format_t f[8] = '{rdl_pkg::FMT_ESF, rdl_pkg::FMT_ESF, rdl_pkg::FMT_ESF,
            rdl_pkg::FMT_ESF, rdl_pkg::FMT_SLC96, rdl_pkg::FMT_N, rdl_pkg::FMT_T1DM, rdl_pkg::FMT_SF};
        logic [1:0] rt[8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h1, 2'h2};
        logic [3:0] m[8] = '{4'h5, 4'h1, 4'h4, 4'h5, 4'h5, 4'h5, 4'hf, 4'h5};
        for (int i = 0; i < 8; i++) begin
            lineFormat <= f[i];
            wrChk(12'h10c, {rt[i], 4'h2}, rdl_pkg::AXI_OKAY);
            for (int k = 0; k < 4; k++) begin
                sendBit({3'h6, k == 0}, {1'b1, m[i][k], 1'b0});
            end
        end
        lineFormat <= rdl_pkg::FMT_ESF;
        $display("test_rates done");
    endtask
    task automatic test_de();
        for (int c = 0; c < 4; c++) begin
            wrChk(12'h10c, {c[1:0], 2'h1}, rdl_pkg::AXI_OKAY);
            u_rdl_lapd_model.got.delete();
            sendBit(4'h2, {c == 1 || c == 3, 1'b0, c == 3});
            repeat (3) @(posedge sys_clk);
            chk(u_rdl_lapd_model.got.size(), c == 1, "slot to LAPD");
            if (c == 1) chk(u_rdl_lapd_model.got[0].fromDe, 1'b1, "slot tag");
        end
        $display("test_de done");
    endtask
    task automatic test_fifo();
        wrChk(12'h10c, 32'h0, rdl_pkg::AXI_OKAY);
        stall <= 1'b1;
        u_rdl_lapd_model.got.delete();
        for (int k = 0; k < 16; k++) sendBit({k[0], 3'h5}, {k[0], 2'h0});
        rdChk(12'h110, 32'h110, rdl_pkg::AXI_OKAY);
        @(posedge sys_clk);
        inBit <= 4'h5; inValid <= 1'b1;
        repeat (4) begin
            @(negedge sys_clk);
            chk(inReady, 1'b0, "full buffer refuses");
        end
        @(posedge sys_clk);
        stall <= 1'b0;
        while (inReady !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        inValid <= 1'b0;
        while (lapdValid !== 1'b0 || u_rdl_lapd_model.got.size() < 17) @(negedge sys_clk);
        chk(u_rdl_lapd_model.got.size(), 17, "drained count");
        for (int k = 0; k < u_rdl_lapd_model.got.size(); k++) begin
            chk(u_rdl_lapd_model.got[k], {1'b0, k[0] && k < 16}, "drained item");
        end
        $display("test_fifo done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and main sequence
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1; s_awvalid = 1'b0; s_wvalid = 1'b0; s_bready = 1'b0; s_arvalid = 1'b0;
        s_rready = 1'b0; s_awaddr = 12'h0; s_araddr = 12'h0; s_wdata = 32'h0; s_wstrb = 4'hf;
        inValid = 1'b0; inBit = 4'h0; stall = 1'b0; lineFormat = rdl_pkg::FMT_ESF;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        test_regs();
        test_link_routes();
        test_rates();
        test_de();
        test_fifo();
        test_done();
    end
endmodule
